// ===== include/gpb_pkg.sv
// constants, field codes and carrier types for the 16-pin port register bank
// assumes one AHB-Lite slave per port and whole-word register accesses only
package gpb_pkg;

   localparam int NPIN = 16;

   // register byte offsets, low six address bits
   localparam logic [5:0] OFF_MODE  = 6'h00;
   localparam logic [5:0] OFF_OTYPE = 6'h04;
   localparam logic [5:0] OFF_SPEED = 6'h08;
   localparam logic [5:0] OFF_PULL  = 6'h0c;
   localparam logic [5:0] OFF_IN    = 6'h10;
   localparam logic [5:0] OFF_OUT   = 6'h14;
   localparam logic [5:0] OFF_BSC   = 6'h18;
   localparam logic [5:0] OFF_LOCK  = 6'h1c;
   localparam logic [5:0] OFF_BR    = 6'h28;

   // values after reset; the port A set keeps its debug pins configured
   localparam logic [31:0] RST_MODE_A  = 32'h2800_0000;
   localparam logic [31:0] RST_SPEED_A = 32'h0c00_0000;
   localparam logic [31:0] RST_PULL_A  = 32'h2400_0000;
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;

   // pin_function_select codes
   localparam logic [1:0] MODE_IN  = 2'h0;
   localparam logic [1:0] MODE_OUT = 2'h1;
   localparam logic [1:0] MODE_ALT = 2'h2;
   localparam logic [1:0] MODE_ANA = 2'h3;

   // resistor_select codes, 2'h3 is reserved and enables nothing
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DN = 2'h2;

   // freeze_key position in the lock register
   localparam int KEY_BIT = 16;

   // AHB transfer type bit that marks NONSEQ or SEQ
   localparam int HTRANS_ACT = 1;

   // freeze key sequence states
   typedef enum logic [1:0] {LK_IDLE, LK_ONE, LK_ZERO, LK_ARMED} gpb_lk_t;

   // per-pin configuration handed to the pad ring
   typedef struct packed {
      logic [31:0] func;
      logic [15:0] drive_type;
      logic [31:0] slew;
   } gpb_cfg_t;

   // pad controls, one bit per pin
   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
      logic [15:0] pull_up;
      logic [15:0] pull_dn;
   } gpb_pad_t;

   // alternate peripheral drive into the pin mux
   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } gpb_alt_t;

endpackage

// ===== hw/gpb_port.sv
// one 16-pin general-purpose port: registers, set/clear, freeze key, pad mux
// assumes an AHB-Lite master on hclk, pins asynchronous, periph_rst on hclk
`timescale 1ns/1ps

// What this block does
// R1: two-bit function per pin: input after reset (port A pins 13, 14 alternate), output, alternate, analog.
// R2: one drive bit per pin: zero push-pull at reset, one open-drain.
// R3: two-bit slew per pin: low bit zero low, 01 medium, 11 high.
// R4: two-bit resistor per pin: none, pull-up, pull-down, 11 reserved.
// R5: input register shows sixteen sampled pins low, upper half reads zero.
// R6: pins are captured into the input register every clock.
// R7: output register holds sixteen writable bits, zero at reset.
// R8: set/clear register low bit one sets the output bit.
// R9: set/clear register bit 16+n one clears output bit n.
// R10: set and clear on one bit together: set wins.
// R11: set/clear register is write-only, reads zero, read has no effect.
// R12: clear-only register write-only, reads zero, ones clear output bits.
// R13: sixteen freeze bits mark pins; writable only while key reads zero.
// R14: software writes key one, zero, one with same pattern, then reads.
// R15: changed pattern or wrong step aborts the key sequence.
// R16: after the sequence the lock register freezes, key reads one.
// R17: once engaged, configuration writes to frozen pins are ignored.
// R18: port A resets function, slew and resistor fields to nonzero values.
// R19: analog pin disables its sampler, its input bit reads zero.
// R20: frozen pins protect configuration fields; output data stays writable.
module gpb_port
   import gpb_pkg::*;
#(
   parameter bit IS_PORT_A = 1'b0
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        periph_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic [15:0] pin_in,
   input  gpb_alt_t         alt_drive,
   output gpb_cfg_t         pin_cfg,
   output gpb_pad_t         pad,
   output logic [15:0]      frozen_pins
);

   // reset values picked by port flavour (R18)
   localparam logic [31:0] MODE_RST  = IS_PORT_A ? RST_MODE_A  : RST_ZERO; // R18
   localparam logic [31:0] SPEED_RST = IS_PORT_A ? RST_SPEED_A : RST_ZERO; // R18
   localparam logic [31:0] PULL_RST  = IS_PORT_A ? RST_PULL_A  : RST_ZERO; // R18

   // widen a per-pin mask to the two-bit fields
   function automatic logic [31:0] expand2(input logic [15:0] m);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int i = 0; i < NPIN; i++)
      begin
         r[2*i+:2] = {2{m[i]}};
      end
      return r;
   endfunction

   // mask of pins whose function is analog
   function automatic logic [15:0] analog_of(input logic [31:0] f);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < NPIN; i++)
      begin
         r[i] = (f[2*i+:2] == MODE_ANA);
      end
      return r;
   endfunction

   logic [31:0] mode_q,  mode_d;
   logic [15:0] otype_q, otype_d;
   logic [31:0] speed_q, speed_d;
   logic [31:0] pull_q,  pull_d;
   logic [15:0] in_q,    in_d;
   logic [15:0] out_q,   out_d;
   logic [15:0] lock_q,  lock_d;
   logic        key_q,   key_d;
   logic [15:0] pat_q,   pat_d;
   gpb_lk_t     lst_q,   lst_d;
   logic [15:0] sync1_q, sync2_q;
   logic        wr_q,    wr_d;
   logic [5:0]  waddr_q, waddr_d;
   logic        rd_q,    rd_d;
   logic [5:0]  raddr_q, raddr_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ready_q;
   gpb_pad_t    pad_q,   pad_d;
   logic [15:0] frz_q,   frz_d;
   logic [15:0] frz_now;
   logic [31:0] frz2;
   logic        take;
   logic [3:0]  pin_nx [NPIN];

   // only word transfers are used, so hsize is not decoded
   assign take    = hsel & htrans[HTRANS_ACT] & hready;
   assign frz_now = key_q ? lock_q : 16'h0000;
   assign frz2    = expand2(frz_now);

   // bus phase capture; the slave never inserts wait states
   always_comb
   begin
      wr_d    = take & hwrite;
      rd_d    = take & ~hwrite;
      waddr_d = take ? {haddr[5:2], 2'h0} : waddr_q;
      raddr_d = take ? {haddr[5:2], 2'h0} : raddr_q;
   end

   // register next values; writes land in the data phase
   always_comb
   begin
      mode_d  = mode_q;
      otype_d = otype_q;
      speed_d = speed_q;
      pull_d  = pull_q;
      out_d   = out_q;
      lock_d  = lock_q;
      key_d   = key_q;
      pat_d   = pat_q;
      lst_d   = lst_q;
      in_d    = sync2_q & ~analog_of(mode_q); // R6 R19
      if (wr_q)
      begin
         unique case (waddr_q)
            OFF_MODE:  mode_d  = (mode_q & frz2) | (hwdata & ~frz2); // R1 R17 R20
            OFF_OTYPE: otype_d = (otype_q & frz_now) | (hwdata[15:0] & ~frz_now); // R2 R17
            OFF_SPEED: speed_d = (speed_q & frz2) | (hwdata & ~frz2); // R3 R17
            OFF_PULL:  pull_d  = (pull_q & frz2) | (hwdata & ~frz2); // R4 R17
            OFF_OUT:   out_d   = hwdata[15:0]; // R7 R20
            OFF_BSC:   out_d   = (out_q & ~hwdata[31:16]) | hwdata[15:0]; // R8 R9 R10
            OFF_BR:    out_d   = out_q & ~hwdata[15:0]; // R12
            OFF_LOCK:
            begin
               // once the key is set the whole register is frozen
               if (!key_q)
               begin
                  lock_d = hwdata[15:0]; // R13
                  unique case (lst_q)
                     LK_IDLE:
                     begin
                        lst_d = hwdata[KEY_BIT] ? LK_ONE : LK_IDLE;
                        pat_d = hwdata[15:0];
                     end
                     LK_ONE:
                        lst_d = (!hwdata[KEY_BIT] && hwdata[15:0] == pat_q)
                              ? LK_ZERO : LK_IDLE; // R15
                     LK_ZERO:
                        lst_d = (hwdata[KEY_BIT] && hwdata[15:0] == pat_q)
                              ? LK_ARMED : LK_IDLE; // R15
                     LK_ARMED:
                        lst_d = LK_IDLE; // R15
                  endcase
               end
            end
            default: ;
         endcase
      end
      // the closing read may overlap the data phase of the third write
      if (rd_d && raddr_d == OFF_LOCK && lst_d == LK_ARMED) // R14
      begin
         key_d = 1'b1; // R16
         lst_d = LK_IDLE;
      end
      // peripheral reset drops the lock along with the key
      if (periph_rst)
      begin
         lock_d = 16'h0000; // R16
         key_d  = 1'b0;
         lst_d  = LK_IDLE;
      end
   end

   // read data from next values so a read right after a write sees it
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (rd_d)
      begin
         unique case (raddr_d)
            OFF_MODE:  rdata_d = mode_d;
            OFF_OTYPE: rdata_d = {16'h0000, otype_d};
            OFF_SPEED: rdata_d = speed_d;
            OFF_PULL:  rdata_d = pull_d;
            OFF_IN:    rdata_d = {16'h0000, in_d}; // R5
            OFF_OUT:   rdata_d = {16'h0000, out_d}; // R7
            OFF_LOCK:  rdata_d = {15'h0000, key_d, lock_d}; // R16
            default:   rdata_d = 32'h0000_0000; // R11 R12
         endcase
      end
   end

   // per-pin pad mux; open-drain drives only a low level
   for (genvar i = 0; i < NPIN; i++)
   begin : g_pin
      logic [1:0] fn;
      logic       src;
      logic       en;
      assign fn  = mode_q[2*i+:2];
      assign src = (fn == MODE_ALT) ? alt_drive.out[i] : out_q[i];
      assign en  = (fn == MODE_OUT) | ((fn == MODE_ALT) & alt_drive.oe[i]); // R1
      assign pin_nx[i] = {src & en,
                          en & (~otype_q[i] | ~src), // R2
                          (fn != MODE_ANA) & (pull_q[2*i+:2] == PULL_UP), // R4 R19
                          (fn != MODE_ANA) & (pull_q[2*i+:2] == PULL_DN)}; // R4 R19
   end

   // gather pad controls into the carrier
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         pad_d.out[i]     = pin_nx[i][3];
         pad_d.oe[i]      = pin_nx[i][2];
         pad_d.pull_up[i] = pin_nx[i][1];
         pad_d.pull_dn[i] = pin_nx[i][0];
      end
      frz_d = key_d ? lock_d : 16'h0000; // R20
   end

   // all state registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q  <= MODE_RST; // R1 R18
         otype_q <= 16'h0000; // R2
         speed_q <= SPEED_RST;
         pull_q  <= PULL_RST;
         in_q    <= 16'h0000;
         out_q   <= 16'h0000; // R7
         lock_q  <= 16'h0000;
         key_q   <= 1'b0;
         pat_q   <= 16'h0000;
         lst_q   <= LK_IDLE;
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
         wr_q    <= 1'b0;
         waddr_q <= 6'h00;
         rd_q    <= 1'b0;
         raddr_q <= 6'h00;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         pad_q   <= '0;
         frz_q   <= 16'h0000;
      end
      else
      begin
         mode_q  <= mode_d;
         otype_q <= otype_d;
         speed_q <= speed_d;
         pull_q  <= pull_d;
         in_q    <= in_d; // R6
         out_q   <= out_d;
         lock_q  <= lock_d;
         key_q   <= key_d;
         pat_q   <= pat_d;
         lst_q   <= lst_d;
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         wr_q    <= wr_d;
         waddr_q <= waddr_d;
         rd_q    <= rd_d;
         raddr_q <= raddr_d;
         rdata_q <= rdata_d;
         ready_q <= 1'b1;
         pad_q   <= pad_d;
         frz_q   <= frz_d;
      end
   end

   // outputs straight from flops, hresp tied low
   assign hreadyout   = ready_q;
   assign hrdata      = rdata_q;
   assign hresp       = 1'b0;
   assign pad         = pad_q;
   assign frozen_pins = frz_q;
   assign pin_cfg     = '{func: mode_q, drive_type: otype_q, slew: speed_q};

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // set/clear register updates output data, set winning
   AST_BSC_SET: assert property (wr_q && waddr_q == OFF_BSC |=> // R8
      (out_q & $past(hwdata[15:0])) == $past(hwdata[15:0]))
      else $error("set request did not raise output bit");
   AST_BSC_CLR: assert property (wr_q && waddr_q == OFF_BSC |=> // R9
      (out_q & $past(hwdata[31:16] & ~hwdata[15:0])) == 16'h0000)
      else $error("clear request did not lower output bit");
   AST_SET_WINS: assert property (wr_q && waddr_q == OFF_BSC // R10
      && (hwdata[15:0] & hwdata[31:16]) != 16'h0000 |=>
      (out_q & $past(hwdata[15:0] & hwdata[31:16])) != 16'h0000)
      else $error("clear beat set on same bit");
   AST_BSC_READ_ZERO: assert property (rd_q && raddr_q == OFF_BSC |-> // R11
      hrdata == 32'h0000_0000 && $stable(out_q))
      else $error("set/clear register read not zero");
   AST_BR_CLEAR: assert property (wr_q && waddr_q == OFF_BR |=> // R12
      out_q == ($past(out_q) & ~$past(hwdata[15:0])))
      else $error("clear-only write wrong");
   AST_IN_UPPER_ZERO: assert property (rd_q && raddr_q == OFF_IN |-> // R5
      hrdata[31:16] == 16'h0000)
      else $error("input register upper half not zero");
   AST_IN_FOLLOWS: assert property (##1 in_q == // R6 R19
      ($past(sync2_q) & ~analog_of($past(mode_q))))
      else $error("input register not sampled");
   AST_ANALOG_QUIET: assert property ((in_q & analog_of(mode_q)) == 16'h0000 // R19
      || $changed(mode_q))
      else $error("analog pin input bit not zero");
   AST_OD_NO_HIGH: assert property ( // R2
      (pad_q.oe & pad_q.out & $past(otype_q)) == 16'h0000)
      else $error("open-drain pin drove high");
   AST_PULL_EXCL: assert property ((pad_q.pull_up & pad_q.pull_dn) == 16'h0000) // R4
      else $error("both resistors enabled");
   AST_ABORT: assert property (wr_q && waddr_q == OFF_LOCK && !key_q // R15
      && lst_q == LK_ONE && hwdata[15:0] != pat_q |=> lst_q == LK_IDLE && !key_q)
      else $error("changed pattern did not abort");
   AST_KEY_STICKS: assert property (key_q && !periph_rst |=> // R16
      key_q && $stable(lock_q))
      else $error("lock register changed while engaged");
   AST_FROZEN_MODE: assert property (wr_q && waddr_q == OFF_MODE && key_q // R17
      && !periph_rst |=> (mode_q & $past(frz2)) == $past(mode_q & frz2))
      else $error("frozen pin function changed");
   AST_LOCK_ENGAGE: assert property (rd_d && raddr_d == OFF_LOCK // R14
      && lst_q == LK_ARMED && !wr_q && !periph_rst |=> key_q && hrdata[KEY_BIT])
      else $error("closing read did not engage key");

   // plain writes, freeze bits and the other frozen fields
   AST_OUT_WRITE: assert property (wr_q && waddr_q == OFF_OUT |=> // R7 R20
      out_q == $past(hwdata[15:0]))
      else $error("output register write lost");
   AST_LOCK_WRITE: assert property (wr_q && waddr_q == OFF_LOCK && !key_q // R13
      && !periph_rst |=> lock_q == $past(hwdata[15:0]))
      else $error("freeze bits not written while key clear");
   AST_FROZEN_OTYPE: assert property (wr_q && waddr_q == OFF_OTYPE && key_q // R17 R20
      && !periph_rst |=> (otype_q & $past(frz_now)) == $past(otype_q & frz_now))
      else $error("frozen pin drive type changed");
   AST_FROZEN_SPEED: assert property (wr_q && waddr_q == OFF_SPEED && key_q // R3 R17
      && !periph_rst |=> (speed_q & $past(frz2)) == $past(speed_q & frz2))
      else $error("frozen pin slew changed");
   AST_FROZEN_PULL: assert property (wr_q && waddr_q == OFF_PULL && key_q // R4 R17
      && !periph_rst |=> (pull_q & $past(frz2)) == $past(pull_q & frz2))
      else $error("frozen pin resistor changed");
   AST_KEY_READ: assert property (rd_q && raddr_q == OFF_LOCK && key_q |-> // R16
      hrdata[KEY_BIT])
      else $error("engaged key read as zero");
   AST_ANALOG_PAD: assert property (((pad_q.oe | pad_q.pull_up | pad_q.pull_dn) // R19
      & analog_of($past(mode_q))) == 16'h0000)
      else $error("analog pin pad not released");
   AST_OTYPE_UPPER: assert property (rd_q && raddr_q == OFF_OTYPE |-> // R2
      hrdata[31:16] == 16'h0000)
      else $error("drive type register upper half not zero");
   AST_OUT_UPPER: assert property (rd_q && raddr_q == OFF_OUT |-> // R7
      hrdata[31:16] == 16'h0000)
      else $error("output register upper half not zero");
   AST_HRDATA_IDLE: assert property (!rd_q |-> hrdata == 32'h0000_0000)
      else $error("read data outside a data phase");

   CVR_KEY_ON: cover property (!key_q ##1 key_q);
   CVR_SET_CLEAR: cover property (wr_q && waddr_q == OFF_BSC
      && (hwdata[15:0] & hwdata[31:16]) != 16'h0000);
   CVR_ABORT: cover property (lst_q == LK_ZERO ##1 lst_q == LK_IDLE);
   CVR_ANALOG: cover property (analog_of(mode_q) != 16'h0000 && rd_q && raddr_q == OFF_IN);
   CVR_FROZEN_WRITE: cover property (wr_q && waddr_q == OFF_MODE && key_q);

endmodule // gpb_port

// ===== tb/gpb_pin_model.sv
// external pin model: resolves each pin from pad drive, bench drive and pulls
// assumes one clock; an undriven, unpulled pin toggles every cycle
`timescale 1ns/1ps
module gpb_pin_model
   import gpb_pkg::*;
(
   input  wire logic        hclk,
   input  wire gpb_pad_t    pad,
   input  wire logic [15:0] ext_en,
   input  wire logic [15:0] ext_lvl,
   output logic [15:0]      pin_in
);
   logic [15:0] float_q = 16'h5a5a;

   // floating pins wander so no test can lean on a settled level
   always @(posedge hclk)
      float_q <= ~float_q;

   // pad driver wins, then the bench driver, then the resistors
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (pad.oe[i])
            pin_in[i] = pad.out[i];
         else if (ext_en[i])
            pin_in[i] = ext_lvl[i];
         else if (pad.pull_up[i])
            pin_in[i] = 1'b1;
         else if (pad.pull_dn[i])
            pin_in[i] = 1'b0;
         else
            pin_in[i] = float_q[i];
      end
   end
endmodule // gpb_pin_model

// ===== tb/tb_gpio_port_register_bank.sv
// self-checking bench for the port register bank, built with port A resets
// assumes gpb_pkg, gpb_port and gpb_pin_model are compiled before it
`timescale 1ns/1ps
module tb_gpio_port_register_bank;
   import gpb_pkg::*;
   logic        hclk       = 1'b0;
   logic        hresetn    = 1'b0;
   logic        periph_rst = 1'b0;
   logic        hsel       = 1'b0;
   logic [31:0] haddr      = 32'h0;
   logic [1:0]  htrans     = 2'h0;
   logic        hwrite     = 1'b0;
   logic [31:0] hwdata     = 32'h0;
   logic [15:0] ext_en     = 16'hffff;
   logic [15:0] ext_lvl    = 16'h0;
   gpb_alt_t    alt_drive  = '0;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic [31:0] rv;
   logic [15:0] pin_in;
   logic [15:0] frozen_pins;
   gpb_cfg_t    pin_cfg;
   gpb_pad_t    pad;
   int          fail_count = 0;
   int          checks     = 0;
   int          cycles     = 0;
   logic [31:0] rst_tab [8] = '{32'h2800_0000, 32'h0, 32'h0c00_0000, 32'h2400_0000,
                                32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] cfg_tab [4] = '{32'h1b1b_e4e4, 32'h0000_5a3c, 32'h9c9c_3636, 32'h6666_9999};

   gpb_port #(.IS_PORT_A(1'b1)) i_dut (.hclk(hclk), .hresetn(hresetn), .periph_rst(periph_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .pin_in(pin_in), .alt_drive(alt_drive), .pin_cfg(pin_cfg), .pad(pad),
      .frozen_pins(frozen_pins));

   gpb_pin_model i_pins (.hclk(hclk), .pad(pad), .ext_en(ext_en), .ext_lvl(ext_lvl),
      .pin_in(pin_in));

   initial
   begin
      forever #5 hclk = ~hclk;
   end

   // hang guard, well above the two hundred or so cycles the tests need
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one single transfer; hready and read data taken at the rising edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rv = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rv, e);
   endtask

   // pads and the input synchroniser need a few edges to follow
   task automatic settle();
      repeat (4) @(posedge hclk);
   endtask

   // peripheral reset pulse, also a clean start for the key sequence
   task automatic prst();
      periph_rst <= 1'b1;
      @(posedge hclk);
      periph_rst <= 1'b0;
   endtask

   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      // reset values, then plain read-back of the four config registers
      for (int i = 0; i < 8; i++)
         rd(4 * i, rst_tab[i]);
      for (int i = 0; i < 4; i++)
      begin
         wr(4 * i, cfg_tab[i]);
         rd(4 * i, cfg_tab[i]);
      end
      chk(pin_cfg.func, cfg_tab[0]);
      chk({16'h0, pin_cfg.drive_type}, cfg_tab[1]);
      chk(pin_cfg.slew, cfg_tab[2]);
      // output data, set/clear with overlap, clear-only, read-only, unmapped
      wr(32'h10, 32'hffff_ffff);
      rd(32'h10, 32'h0);
      wr(32'h14, 32'h0000_a5a5);
      rd(32'h14, 32'h0000_a5a5);
      wr(32'h18, 32'h00ff_0f0f);
      rd(32'h18, 32'h0);
      rd(32'h14, 32'h0000_af0f);
      wr(32'h28, 32'hffff_000f);
      rd(32'h28, 32'h0);
      rd(32'h14, 32'h0000_af00);
      wr(32'h20, 32'hffff_ffff);
      rd(32'h20, 32'h0);
      // push-pull outputs looped back, then upper pins analog
      ext_en <= 16'h0;
      wr(32'h00, 32'h5555_5555);
      wr(32'h04, 32'h0);
      wr(32'h0c, 32'h0);
      wr(32'h14, 32'h0000_c3a5);
      settle();
      chk({pad.oe, pad.out}, 32'hffff_c3a5);
      rd(32'h10, 32'h0000_c3a5);
      wr(32'h00, 32'hffff_5555);
      settle();
      chk({16'h0, pad.oe}, 32'h0000_00ff);
      rd(32'h10, 32'h0000_00a5);
      // open-drain with pull-ups: only zero bits drive
      wr(32'h00, 32'h5555_5555);
      wr(32'h04, 32'h0000_ffff);
      wr(32'h0c, 32'h5555_5555);
      wr(32'h14, 32'h0000_00ff);
      settle();
      chk({16'h0, pad.oe}, 32'h0000_ff00);
      rd(32'h10, 32'h0000_00ff);
      // inputs held by resistors, then the reserved code
      wr(32'h00, 32'h0);
      wr(32'h0c, 32'haaaa_5555);
      settle();
      chk({pad.pull_up, pad.pull_dn}, 32'h00ff_ff00);
      rd(32'h10, 32'h0000_00ff);
      wr(32'h0c, 32'hffff_ffff);
      settle();
      chk({pad.pull_up, pad.pull_dn}, 32'h0);
      // alternate function drives the pads
      wr(32'h04, 32'h0);
      wr(32'h00, 32'haaaa_aaaa);
      alt_drive <= {16'h1234, 16'hffff};
      settle();
      chk({pad.oe, pad.out}, 32'hffff_1234);
      rd(32'h10, 32'h0000_1234);
      // key sequence aborted by a changed pattern, then by a late write
      wr(32'h00, 32'h0);
      prst();
      wr(32'h1c, 32'h0001_0001);
      wr(32'h1c, 32'h0000_0002);
      wr(32'h1c, 32'h0001_0001);
      rd(32'h1c, 32'h0000_0001);
      prst();
      wr(32'h1c, 32'h0001_0001);
      wr(32'h1c, 32'h0000_0001);
      wr(32'h1c, 32'h0001_0001);
      wr(32'h1c, 32'h0001_0001);
      rd(32'h1c, 32'h0000_0001);
      // full sequence freezes pins 0 and 1
      prst();
      wr(32'h1c, 32'h0001_0003);
      wr(32'h1c, 32'h0000_0003);
      wr(32'h1c, 32'h0001_0003);
      rd(32'h1c, 32'h0001_0003);
      chk({16'h0, frozen_pins}, 32'h0000_0003);
      wr(32'h1c, 32'h0);
      rd(32'h1c, 32'h0001_0003);
      wr(32'h00, 32'hffff_ffff);
      rd(32'h00, 32'hffff_fff0);
      wr(32'h04, 32'h0000_ffff);
      rd(32'h04, 32'h0000_fffc);
      wr(32'h14, 32'h0000_ffff);
      rd(32'h14, 32'h0000_ffff);
      wr(32'h08, 32'hffff_ffff);
      rd(32'h08, 32'hffff_fff6);
      wr(32'h0c, 32'h0);
      rd(32'h0c, 32'h0000_000f);
      prst();
      rd(32'h1c, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      wrap_up();
   end
endmodule // tb_gpio_port_register_bank
